/* tb.sv */
// Self-checking bench for the tunnel header framer
`include "thf_framer_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // Signals and table
  // --------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, rx_accept, rx_drop;
  wire hready = hreadyout;
  wire rx_hdr_valid, rx_has_udp, rx_is_ctrl, rx_is_initial;
  wire [47:0] rx_dst_mac;
  wire [31:0] rx_src_ip;
  wire [15:0] rx_src_port, rx_dst_port;
  logic tx_req = 1'b0;
  logic [1:0] tx_class = 2'h0;
  logic [2:0] tx_flow = 3'h0;
  logic [5:0] tx_req_dscp = 6'h0;
  logic [15:0] tx_len = 16'h0054;
  logic [15:0] tx_ident = 16'h0;
  logic tx_hdr_valid, tx_err, tx_df, tx_udp_en;
  logic [47:0] tx_dst_mac;
  logic [31:0] tx_src_ip, tx_dst_ip;
  logic [5:0] tx_dscp;
  logic [7:0] tx_proto;
  logic [15:0] tx_src_port, tx_dst_port, tx_ip_csum;
  int error_cnt = 0;
  int tests_run = 0;
  typedef struct packed {logic [7:0] a; logic [8:0] d; logic [1:0] c;
    logic [2:0] f; logic [5:0] r; logic [5:0] e;} thf_row_t;
  thf_row_t rows [8] = '{
    '{`THF_A_CTRL_QOS, 9'h000, `THF_CLS_CTRL, 3'h0, 6'h05, 6'h00},
    '{`THF_A_CTRL_QOS, 9'h112, `THF_CLS_CTRL, 3'h0, 6'h05, 6'h12},
    '{`THF_A_PROBE_QOS, 9'h021, `THF_CLS_PROBE, 3'h0, 6'h07, 6'h07},
    '{`THF_A_PROBE_QOS, 9'h121, `THF_CLS_PROBE, 3'h0, 6'h07, 6'h21},
    '{`THF_A_SBFD_QOS, 9'h02a, `THF_CLS_SBFD, 3'h0, 6'h09, 6'h09},
    '{`THF_A_SBFD_QOS, 9'h12a, `THF_CLS_SBFD, 3'h0, 6'h09, 6'h2a},
    '{8'h5c, 9'h13f, `THF_CLS_DATA, 3'h7, 6'h01, 6'h3f},
    '{8'h40, 9'h115, `THF_CLS_DATA, 3'h0, 6'h01, 6'h15}};
  thf_framer thf_framer_i (.*);
  thf_core_model thf_core_model_i (.*);
  always #20 sys_clk = ~sys_clk;
  task stop_test;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_rdy;
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1)
        break;
    end
    if (n == 50)
    begin
      error_cnt++;
      stop_test;
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    wait_rdy;
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wait_rdy;
    rd = hrdata;
  endtask
  task tx(input logic [1:0] c, input logic [2:0] f, input logic [5:0] r);
    @(posedge sys_clk);
    {tx_req, tx_class, tx_flow, tx_req_dscp} <= {1'b1, c, f, r};
    tx_len <= tx_len + 16'h0101;
    tx_ident <= tx_ident + 16'h1003;
    @(posedge sys_clk);
    tx_req <= 1'b0;
    #1;
  endtask
  // Bit 3 of k sets the group bit of the destination
  task rx(input logic [31:0] ip, input logic [3:0] k, input logic [15:0] dp,
    input logic ok);
    thf_core_model_i.send({7'h01, k[3], 40'h1}, ip, k[2:0], 16'h1234, dp);
    #1;
    `CHK({rx_accept, rx_drop}, {ok, !ok})
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({tx_df, tx_proto, tx_src_port}, {1'b1, 8'h73, 16'h06a5})
    ahb(1, `THF_A_NODE_IP, 32'h0a000002);
    ahb(1, `THF_A_MAC_HI, 32'h00000200);
    ahb(1, `THF_A_MAC_LO, 32'h11223344);
    for (int i = 0; i < 4; i++)
      ahb(1, 8'h30 + 8'(i * 4), 32'h0a010000 + i);
    ahb(1, `THF_A_CORE_VALID, 32'hf);
    ahb(1, `THF_A_CTRL, 32'h1);
    ahb(0, `THF_A_NODE_PORT, 32'h0);
    `CHK(rd, 32'h000006a5)
    ahb(0, 8'h80, 32'h0);
    `CHK(rd, 32'h0)
    rx(32'h0a010003, 4'hf, 16'h06a5, 0);
    rx(32'h0a0100ff, 4'h7, 16'h06a5, 0);
    rx(32'h0a010003, 4'h7, 16'h0077, 0);
    rx(32'h0a010003, 4'h7, 16'h06a5, 1);
    ahb(0, `THF_A_STATUS, 32'h0);
    `CHK(rd, {16'h1234, 8'h03, 8'h0f})
    foreach (rows[i])
    begin
      ahb(1, rows[i].a, {23'h0, rows[i].d});
      tx(rows[i].c, rows[i].f, rows[i].r);
      `CHK(tx_dscp, rows[i].e)
      `CHK({tx_hdr_valid, tx_err, tx_udp_en, tx_proto}, 11'h511)
      `CHK({tx_src_ip, tx_dst_ip}, 64'h0a000002_0a010003)
      `CHK({tx_src_port, tx_dst_port}, 32'h06a5_1234)
      `CHK(tx_dst_mac, 48'h020011223344)
    end
    rx(32'h0a010000, 4'h6, 16'h06a5, 0);
    rx(32'h0a010003, 4'h6, 16'h0077, 0);
    rx(32'h0a010003, 4'h6, 16'h06a5, 1);
    ahb(0, `THF_A_CTRL, 32'h0);
    `CHK(rd, 32'h00000001)
    // A moved node port must be used for the rest of the link
    ahb(1, `THF_A_NODE_PORT, 32'h00001a2b);
    rx(32'h0a010003, 4'h6, 16'h06a5, 0);
    rx(32'h0a010003, 4'h6, 16'h1a2b, 1);
    tx(`THF_CLS_CTRL, 3'h0, 6'h00);
    `CHK({tx_src_port, tx_dst_port}, 32'h1a2b_1234)
    // Mid-run reset drops the session and UDP capability
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tx(`THF_CLS_CTRL, 3'h0, 6'h00);
    `CHK({tx_err, tx_udp_en, tx_proto}, 10'h273)
    ahb(1, 8'h30, 32'h0a010000);
    ahb(1, `THF_A_CORE_VALID, 32'h1);
    rx(32'h0a010000, 4'h7, 16'h06a5, 0);
    rx(32'h0a010000, 4'h3, 16'h06a5, 1);
    tx(`THF_CLS_DATA, 3'h3, 6'h00);
    `CHK({tx_err, tx_udp_en, tx_proto}, 10'h073)
    `CHK(tx_dst_ip, 32'h0a010000)
    stop_test;
  end
endmodule // tb

/* thf_core_model.sv */
// Behavioural headend core sending headers to the framer
module thf_core_model (
  // Clock
  input wire logic sys_clk,
  // Received header fields
  output logic rx_hdr_valid,
  output logic [47:0] rx_dst_mac,
  output logic [31:0] rx_src_ip,
  output logic rx_has_udp,
  output logic [15:0] rx_src_port,
  output logic [15:0] rx_dst_port,
  output logic rx_is_ctrl,
  output logic rx_is_initial
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {rx_hdr_valid, rx_dst_mac, rx_src_ip, rx_has_udp} = '0;
    {rx_src_port, rx_dst_port, rx_is_ctrl, rx_is_initial} = '0;
  end
  // --------------------------------------------------------------------
  // One header; MAC, IP and port fields scramble after it, the three flags hold their values
  // --------------------------------------------------------------------
  task send(input logic [47:0] mac, input logic [31:0] ip,
    input logic [2:0] k, input logic [15:0] sp, input logic [15:0] dp);
    @(posedge sys_clk);
    // The core never fragments, so every header opens a whole packet
    rx_hdr_valid <= 1'b1;
    rx_dst_mac <= mac;
    rx_src_ip <= ip;
    {rx_has_udp, rx_is_ctrl, rx_is_initial} <= k;
    {rx_src_port, rx_dst_port} <= {sp, dp};
    @(posedge sys_clk);
    rx_hdr_valid <= 1'b0;
    rx_dst_mac <= ~mac;
    rx_src_ip <= ~ip;
    {rx_src_port, rx_dst_port} <= ~{sp, dp};
  endtask
endmodule // thf_core_model

/* thf_framer.v */
// Tunnel header framer of the remote node with its AHB-Lite registers
`include "thf_framer_regs.vh"

module thf_framer (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Received header check
  input wire rx_hdr_valid,
  input wire [47:0] rx_dst_mac,
  input wire [31:0] rx_src_ip,
  input wire rx_has_udp,
  input wire [15:0] rx_src_port,
  input wire [15:0] rx_dst_port,
  input wire rx_is_ctrl,
  input wire rx_is_initial,
  output reg rx_accept,
  output reg rx_drop,
  // Transmit header build
  input wire tx_req,
  input wire [1:0] tx_class,
  input wire [2:0] tx_flow,
  input wire [5:0] tx_req_dscp,
  input wire [15:0] tx_len,
  input wire [15:0] tx_ident,
  output reg tx_hdr_valid,
  output reg tx_err,
  output reg [47:0] tx_dst_mac,
  output reg [31:0] tx_src_ip,
  output reg [31:0] tx_dst_ip,
  output reg [5:0] tx_dscp,
  output reg tx_df,
  output reg [7:0] tx_proto,
  output reg tx_udp_en,
  output reg [15:0] tx_src_port,
  output reg [15:0] tx_dst_port,
  output reg [15:0] tx_ip_csum
);

  // --------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------
  function in_core;
    input [7:0] a;
    begin
      in_core = (a[7:4] == `THF_CORE_BASE);
    end
  endfunction

  function in_flow;
    input [7:0] a;
    begin
      in_flow = (a[7:5] == `THF_FLOW_BASE);
    end
  endfunction

  // Ones-complement header sum; flags carry DF and a zero offset
  function [15:0] ip_csum;
    input [5:0] d;
    input [15:0] len;
    input [15:0] id;
    input [7:0] pr;
    input [31:0] s;
    input [31:0] t;
    reg [19:0] acc;
    begin
      acc = {4'h0, `THF_IP_VER_IHL, d, 2'b00} + {4'h0, len}
        + {4'h0, id} + {4'h0, `THF_FLAGS_DF} + {4'h0, `THF_TTL, pr}
        + {4'h0, s[31:16]} + {4'h0, s[15:0]}
        + {4'h0, t[31:16]} + {4'h0, t[15:0]};
      acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
      acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
      ip_csum = ~acc[15:0];
    end
  endfunction

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg udp_cap;
  reg [15:0] node_port;
  reg [8:0] ctrl_qos;
  reg [8:0] probe_qos;
  reg [8:0] sbfd_qos;
  reg [47:0] peer_mac;
  reg [31:0] node_ip;
  reg [3:0] core_valid;
  reg [31:0] core_ip [0:3];
  reg [8:0] flow_qos [0:7];
  reg udp_mode;
  reg sess_up;
  reg [1:0] sess_idx;
  reg [15:0] core_port;
  reg [7:0] drop_cnt;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg [31:0] rd_val;
  integer i;

  wire rd_req = hsel & htrans[1] & ~hwrite & hready;

  // --------------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // --------------------------------------------------------------------
  always @*
  begin
    rd_val = 32'h00000000;
    if (haddr[7:0] == `THF_A_CTRL)
      rd_val[`THF_CTRL_UDPCAP] = udp_cap;
    else if (haddr[7:0] == `THF_A_STATUS)
      rd_val = {core_port, drop_cnt, 4'h0, sess_idx, sess_up, udp_mode};
    else if (haddr[7:0] == `THF_A_NODE_PORT)
      rd_val = {16'h0000, node_port};
    else if (haddr[7:0] == `THF_A_CTRL_QOS)
      rd_val = {23'h000000, ctrl_qos};
    else if (haddr[7:0] == `THF_A_PROBE_QOS)
      rd_val = {23'h000000, probe_qos};
    else if (haddr[7:0] == `THF_A_SBFD_QOS)
      rd_val = {23'h000000, sbfd_qos};
    else if (haddr[7:0] == `THF_A_MAC_HI)
      rd_val = {16'h0000, peer_mac[47:32]};
    else if (haddr[7:0] == `THF_A_MAC_LO)
      rd_val = peer_mac[31:0];
    else if (haddr[7:0] == `THF_A_NODE_IP)
      rd_val = node_ip;
    else if (haddr[7:0] == `THF_A_CORE_VALID)
      rd_val = {28'h0000000, core_valid};
    else if (in_core(haddr[7:0]))
      rd_val = core_ip[haddr[3:2]];
    else if (in_flow(haddr[7:0]))
      rd_val = {23'h000000, flow_qos[haddr[4:2]]};
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel & htrans[1] & hwrite & hready;
      wr_addr <= haddr[7:0];
      if (rd_req)
        hrdata <= rd_val;
    end
  end

  // Writes land in the data phase; hsize is not checked, words only
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      udp_cap <= 1'b0;
      node_port <= `THF_PORT_WELL_KNOWN;
      ctrl_qos <= 9'h000;
      probe_qos <= 9'h000;
      sbfd_qos <= 9'h000;
      peer_mac <= 48'h000000000000;
      node_ip <= 32'h00000000;
      core_valid <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        core_ip[i] <= 32'h00000000;
      for (i = 0; i < 8; i = i + 1)
        flow_qos[i] <= 9'h000;
    end
    else if (wr_pend)
    begin
      if (wr_addr == `THF_A_CTRL)
        udp_cap <= hwdata[`THF_CTRL_UDPCAP];
      else if (wr_addr == `THF_A_NODE_PORT)
        node_port <= hwdata[15:0];
      else if (wr_addr == `THF_A_CTRL_QOS)
        ctrl_qos <= hwdata[8:0];
      else if (wr_addr == `THF_A_PROBE_QOS)
        probe_qos <= hwdata[8:0];
      else if (wr_addr == `THF_A_SBFD_QOS)
        sbfd_qos <= hwdata[8:0];
      else if (wr_addr == `THF_A_MAC_HI)
        peer_mac[47:32] <= hwdata[15:0];
      else if (wr_addr == `THF_A_MAC_LO)
        peer_mac[31:0] <= hwdata;
      else if (wr_addr == `THF_A_NODE_IP)
        node_ip <= hwdata;
      else if (wr_addr == `THF_A_CORE_VALID)
        core_valid <= hwdata[3:0];
      else if (in_core(wr_addr))
        core_ip[wr_addr[3:2]] <= hwdata;
      else if (in_flow(wr_addr))
        flow_qos[wr_addr[4:2]] <= hwdata[8:0];
    end
  end

  // --------------------------------------------------------------------
  // Receive check: endpoint match and control port pairing
  // --------------------------------------------------------------------
  wire [3:0] ip_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_match
      assign ip_hit[g] = core_valid[g] & (rx_src_ip == core_ip[g]);
    end
  endgenerate

  wire [1:0] hit_idx = ip_hit[3] ? 2'h3 : ip_hit[2] ? 2'h2 :
    ip_hit[1] ? 2'h1 : 2'h0;
  wire bad_mac = rx_dst_mac[`THF_MAC_GROUP_BIT];
  wire bad_udp = rx_has_udp & ~udp_cap;
  wire bad_init = rx_is_initial & rx_has_udp &
    (rx_dst_port != `THF_PORT_WELL_KNOWN);
  // Later control traffic in UDP mode must keep the learned port pair
  wire bad_pair = sess_up & udp_mode & rx_is_ctrl & ~rx_is_initial &
    ((rx_dst_port != node_port) | (rx_src_port != core_port));
  // Apart from initial requests, control and data must come from the session's own endpoint
  wire bad_sess = sess_up & ~rx_is_initial & ~ip_hit[sess_idx];
  wire rx_ok = ~bad_mac & (|ip_hit) & ~bad_udp & ~bad_init &
    ~bad_pair & ~bad_sess;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_accept <= 1'b0;
      rx_drop <= 1'b0;
      udp_mode <= 1'b0;
      sess_up <= 1'b0;
      sess_idx <= 2'h0;
      core_port <= 16'h0000;
      drop_cnt <= 8'h00;
    end
    else
    begin
      rx_accept <= rx_hdr_valid & rx_ok;
      rx_drop <= rx_hdr_valid & ~rx_ok;
      // Saturates so a flood of bad frames cannot wrap to a clean count
      if (rx_hdr_valid & ~rx_ok & (drop_cnt != 8'hff))
        drop_cnt <= drop_cnt + 8'h01;
      if (rx_hdr_valid & rx_ok & rx_is_ctrl & rx_is_initial)
      begin
        sess_up <= 1'b1;
        sess_idx <= hit_idx;
        core_port <= rx_src_port;
        udp_mode <= udp_cap & rx_has_udp;
      end
    end
  end

  // --------------------------------------------------------------------
  // Transmit header build
  // --------------------------------------------------------------------
  reg [5:0] next_dscp;
  reg [8:0] fq;
  reg [31:0] next_dst_ip;
  reg [7:0] next_proto;

  always @*
  begin
    fq = flow_qos[tx_flow];
    next_dst_ip = core_ip[sess_idx];
    next_proto = udp_mode ? `THF_PROTO_UDP : `THF_PROTO_L2TP;
    case (tx_class)
      `THF_CLS_CTRL:
        next_dscp = ctrl_qos[`THF_QOS_VALID] ? ctrl_qos[5:0] :
          `THF_DSCP_BE;
      `THF_CLS_PROBE:
        next_dscp = probe_qos[`THF_QOS_VALID] ? probe_qos[5:0] :
          tx_req_dscp;
      `THF_CLS_SBFD:
        next_dscp = sbfd_qos[`THF_QOS_VALID] ? sbfd_qos[5:0] :
          tx_req_dscp;
      default:
        next_dscp = fq[`THF_QOS_VALID] ? fq[5:0] : `THF_DSCP_BE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_hdr_valid <= 1'b0;
      tx_err <= 1'b0;
      tx_dst_mac <= 48'h000000000000;
      tx_src_ip <= 32'h00000000;
      tx_dst_ip <= 32'h00000000;
      tx_dscp <= `THF_DSCP_BE;
      tx_df <= 1'b1;
      tx_proto <= `THF_PROTO_L2TP;
      tx_udp_en <= 1'b0;
      tx_src_port <= `THF_PORT_WELL_KNOWN;
      tx_dst_port <= `THF_PORT_WELL_KNOWN;
      tx_ip_csum <= 16'h0000;
    end
    else
    begin
      tx_hdr_valid <= tx_req;
      // No session or a group destination: header is still output with tx_hdr_valid but flagged with tx_err
      tx_err <= tx_req & (peer_mac[`THF_MAC_GROUP_BIT] | ~sess_up);
      tx_df <= 1'b1;
      if (tx_req)
      begin
        tx_dst_mac <= peer_mac;
        tx_src_ip <= node_ip;
        tx_dst_ip <= next_dst_ip;
        tx_dscp <= next_dscp;
        tx_proto <= next_proto;
        tx_udp_en <= udp_mode;
        tx_src_port <= node_port;
        tx_dst_port <= core_port;
        tx_ip_csum <= ip_csum(next_dscp, tx_len, tx_ident, next_proto,
          node_ip, next_dst_ip);
      end
    end
  end

endmodule // thf_framer

/* thf_framer_props.sv */
// Checker on the tunnel header framer ports
module thf_framer_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Receive check
  input wire logic rx_hdr_valid,
  input wire logic [47:0] rx_dst_mac,
  input wire logic rx_has_udp,
  input wire logic [15:0] rx_dst_port,
  input wire logic rx_is_initial,
  input wire logic rx_accept,
  input wire logic rx_drop,
  // Transmit build
  input wire logic tx_req,
  input wire logic [15:0] tx_len,
  input wire logic [15:0] tx_ident,
  input wire logic tx_hdr_valid,
  input wire logic tx_err,
  input wire logic [47:0] tx_dst_mac,
  input wire logic [31:0] tx_src_ip,
  input wire logic [31:0] tx_dst_ip,
  input wire logic [5:0] tx_dscp,
  input wire logic tx_df,
  input wire logic [7:0] tx_proto,
  input wire logic tx_udp_en,
  input wire logic [15:0] tx_ip_csum
);
  // --------------------------------------------------------------------
  // Header sum over the built fields; a valid header folds to all ones
  // --------------------------------------------------------------------
  logic [15:0] len_q;
  logic [15:0] id_q;
  logic [19:0] sum;
  logic [16:0] fold;
  always_ff @(posedge sys_clk)
  begin
    if (tx_req)
    begin
      len_q <= tx_len;
      id_q <= tx_ident;
    end
  end
  always_comb
  begin
    sum = {8'h45, tx_dscp, 2'h0} + len_q + id_q + 16'h4000
      + {8'h40, tx_proto} + tx_ip_csum + tx_src_ip[31:16]
      + tx_src_ip[15:0] + tx_dst_ip[31:16] + tx_dst_ip[15:0];
    fold = sum[15:0] + sum[19:16];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_df; tx_df; endproperty
  a_df: assert property (p_df)
    else $error("do-not-fragment flag low");
  property p_tx_ans; tx_req |=> tx_hdr_valid; endproperty
  a_tx_ans: assert property (p_tx_ans)
    else $error("header build not answered");
  property p_rx_ans;
    !(rx_accept && rx_drop) && ((rx_accept || rx_drop) == $past(rx_hdr_valid));
  endproperty
  a_rx_ans: assert property (p_rx_ans)
    else $error("receive verdict wrong in count or time");
  property p_group; rx_hdr_valid && rx_dst_mac[40] |=> rx_drop; endproperty
  a_group: assert property (p_group)
    else $error("group destination accepted");
  property p_port;
    rx_hdr_valid && rx_is_initial && rx_has_udp && rx_dst_port != 16'h06a5
      |=> rx_drop;
  endproperty
  a_port: assert property (p_port)
    else $error("initial request to wrong port accepted");
  property p_tx_mac; tx_hdr_valid && !tx_err |-> !tx_dst_mac[40]; endproperty
  a_tx_mac: assert property (p_tx_mac)
    else $error("group destination built");
  property p_proto;
    tx_hdr_valid |-> tx_proto == (tx_udp_en ? 8'h11 : 8'h73);
  endproperty
  a_proto: assert property (p_proto)
    else $error("protocol does not match UDP mode");
  property p_csum;
    tx_hdr_valid |-> (fold[15:0] + fold[16]) == 16'hffff;
  endproperty
  a_csum: assert property (p_csum)
    else $error("header checksum invalid");
  property p_hold; !tx_req |=> $stable(tx_dscp) && $stable(tx_dst_ip); endproperty
  a_hold: assert property (p_hold)
    else $error("header fields moved without request");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus)
    else $error("bus not ready or not OKAY");
  c_acc: cover property (rx_accept);
  c_drop: cover property (rx_drop);
  c_udp: cover property (tx_hdr_valid && tx_udp_en);
endmodule // thf_framer_props

bind thf_framer thf_framer_props thf_framer_props_i (.*);

/* thf_framer_regs.vh */
// Constants and register map of the tunnel header framer
`ifndef THF_FRAMER_REGS_VH
`define THF_FRAMER_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define THF_A_CTRL 8'h00
`define THF_A_STATUS 8'h04
`define THF_A_NODE_PORT 8'h08
`define THF_A_CTRL_QOS 8'h0c
`define THF_A_PROBE_QOS 8'h10
`define THF_A_SBFD_QOS 8'h14
`define THF_A_MAC_HI 8'h18
`define THF_A_MAC_LO 8'h1c
`define THF_A_NODE_IP 8'h20
`define THF_A_CORE_VALID 8'h24
`define THF_CORE_BASE 4'h3
`define THF_FLOW_BASE 3'h2

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define THF_CTRL_UDPCAP 0
`define THF_QOS_VALID 8
`define THF_MAC_GROUP_BIT 40
`define THF_PORT_WELL_KNOWN 16'h06a5
`define THF_DSCP_BE 6'h00
`define THF_IP_VER_IHL 8'h45
`define THF_FLAGS_DF 16'h4000
`define THF_TTL 8'h40
`define THF_PROTO_L2TP 8'h73
`define THF_PROTO_UDP 8'h11

// ----------------------------------------------------------------------
// Packet classes on the transmit request
// ----------------------------------------------------------------------
`define THF_CLS_CTRL 2'h0
`define THF_CLS_DATA 2'h1
`define THF_CLS_PROBE 2'h2
`define THF_CLS_SBFD 2'h3

`endif
